// ---- core/fiap_pkg.sv ----
// Package of register map, field layout and timing constants for the flash IN_APP_PROGRAMMING control block
package fiap_pkg;
  localparam int          ADDR_W         = 6;
  localparam int          DATA_W         = 32;
  // Register byte offsets, one aligned word each
  localparam logic [5:0]  OFS_ADDR_LOW   = 6'h00;
  localparam logic [5:0]  OFS_ADDR_HIGH  = 6'h04;
  localparam logic [5:0]  OFS_D0_LOW     = 6'h08;
  localparam logic [5:0]  OFS_D0_HIGH    = 6'h0c;
  localparam logic [5:0]  OFS_D1_LOW     = 6'h10;
  localparam logic [5:0]  OFS_D1_HIGH    = 6'h14;
  localparam logic [5:0]  OFS_D2_LOW     = 6'h18;
  localparam logic [5:0]  OFS_D2_HIGH    = 6'h1c;
  localparam logic [5:0]  OFS_D3_LOW     = 6'h20;
  localparam logic [5:0]  OFS_D3_HIGH    = 6'h24;
  localparam logic [5:0]  OFS_OP_CTRL    = 6'h28;
  localparam logic [5:0]  OFS_CHIP_RST   = 6'h2c;
  localparam logic [5:0]  OFS_BUF_CLR    = 6'h30;
  // Operation control fields
  localparam int          BIT_UNLOCKED   = 7;
  localparam int          SEL_HI         = 6;
  localparam int          SEL_LO         = 4;
  localparam int          BIT_TRIGGER    = 3;
  localparam int          BIT_PROG_GO    = 2;
  localparam int          BIT_READ_ALLOW = 1;
  localparam int          BIT_READ_GO    = 0;
  localparam int          BIT_CLR_GO     = 0;
  localparam logic [7:0]  RST_BYTE       = 8'h00;
  localparam logic [3:0]  ADDR_HIGH_MASK = 4'hf;
  // Operation select encodings
  localparam logic [2:0]  SEL_WRITE      = 3'h0;
  localparam logic [2:0]  SEL_ERASE      = 3'h1;
  localparam logic [2:0]  SEL_READ       = 3'h3;
  localparam logic [2:0]  SEL_UNLOCK     = 3'h6;
  // Unlock pattern for data pairs 1..3
  localparam logic [7:0]  PAT_D1_LOW     = 8'h00;
  localparam logic [7:0]  PAT_D2_LOW     = 8'h0d;
  localparam logic [7:0]  PAT_D3_LOW     = 8'hc3;
  localparam logic [7:0]  PAT_D1_HIGH    = 8'h04;
  localparam logic [7:0]  PAT_D2_HIGH    = 8'h09;
  localparam logic [7:0]  PAT_D3_HIGH    = 8'h40;
  localparam logic [7:0]  CHIP_RST_KEY   = 8'h55;
  // Page geometry
  localparam int          FLASH_AW       = 12;
  localparam int          WORD_BITS      = 5;
  localparam int          PAGE_WORDS     = 32;
  localparam logic [4:0]  LAST_WORD      = 5'h1f;
  // Default durations in cycles of the 100 MHz clock
  localparam int          CLK_NS         = 10;
  localparam int          UNLOCK_NS      = 2000;
  localparam int          PROG_NS        = 20000;
  localparam int          READ_NS        = 100;
  localparam int          UNLOCK_CYC     = UNLOCK_NS / CLK_NS;
  localparam int          PROG_CYC       = PROG_NS / CLK_NS;
  localparam int          READ_CYC       = READ_NS / CLK_NS;
  localparam int          CLEAR_CYC      = PAGE_WORDS;
  localparam int          CNT_W          = 16;
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_UNLOCK = 5'b00010,
    ST_PROG   = 5'b00100,
    ST_READ   = 5'b01000,
    ST_CLEAR  = 5'b10000
  } fiap_state_t;
endpackage : fiap_pkg

// ---- core/fiap_ctrl.sv ----
// Flash IN_APP_PROGRAMMING control registers with Wishbone slave, unlock timer and operation sequencer
//
// Local design decisions: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module fiap_ctrl #(
  parameter int UNLOCK_CYCLES = fiap_pkg::UNLOCK_CYC,  // Unlock window length
  parameter int PROG_CYCLES   = fiap_pkg::PROG_CYC,    // Erase/write duration
  parameter int READ_CYCLES   = fiap_pkg::READ_CYC     // Read duration
) (
  input  wire logic                        i_core_clk,     // System clock
  input  wire logic                        i_arst_n,       // Async reset, active low
  input  wire logic                        i_wb_cyc,       // Wishbone cycle
  input  wire logic                        i_wb_stb,       // Wishbone strobe
  input  wire logic                        i_wb_we,        // Wishbone write
  input  wire logic [fiap_pkg::ADDR_W-1:0] i_wb_adr,       // Byte address
  input  wire logic [fiap_pkg::DATA_W-1:0] i_wb_dat,       // Write data
  input  wire logic [3:0]                  i_wb_sel,       // Byte selects
  output logic      [fiap_pkg::DATA_W-1:0] o_wb_dat,       // Read data
  output logic                             o_wb_ack,       // Acknowledge
  output logic                             o_cpu_stall,    // CPU halt request
  output logic                             o_chip_rst,     // Chip reset pulse
  output logic                             o_fl_wr,        // Program page strobe
  output logic                             o_fl_erase,     // Erase page strobe
  output logic                             o_fl_rd,        // Read word strobe
  output logic      [fiap_pkg::FLASH_AW-1:0] o_fl_addr,    // Flash word address
  output logic      [15:0]                 o_fl_wdata,     // Buffer word at o_fl_addr
  input  wire logic [15:0]                 i_fl_rdata      // Flash read word
);
  import fiap_pkg::*;

  logic [7:0]  addr_low_r, addr_low_nxt;
  logic [3:0]  addr_high_r, addr_high_nxt;
  logic [7:0]  d_low_r [4];
  logic [7:0]  d_low_nxt [4];
  logic [7:0]  d_high_r [4];
  logic [7:0]  d_high_nxt [4];
  logic        unlocked_r, unlocked_nxt;
  logic [2:0]  sel_r, sel_nxt;
  logic        trig_r, trig_nxt;
  logic        prog_go_r, prog_go_nxt;
  logic        rd_allow_r, rd_allow_nxt;
  logic        rd_go_r, rd_go_nxt;
  logic [7:0]  rst_pat_r, rst_pat_nxt;
  logic        clr_go_r, clr_go_nxt;
  logic        ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic        chip_rst_r, chip_rst_nxt;
  fiap_state_t st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [15:0] buf_r [PAGE_WORDS];
  logic [15:0] buf_nxt [PAGE_WORDS];
  logic [PAGE_WORDS-1:0] tag_r, tag_nxt;
  logic        wr_go, rd_go;
  logic [7:0]  wbyte;
  logic        pat_ok;
  logic [FLASH_AW-1:0] faddr;

  // Fresh request only: the ack cycle must not be counted twice
  assign wr_go = i_wb_cyc && i_wb_stb && i_wb_we && !ack_r && i_wb_sel[0];
  assign rd_go = i_wb_cyc && i_wb_stb && !ack_r;
  assign wbyte = i_wb_dat[7:0];
  assign faddr = {addr_high_r, addr_low_r};

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic [CNT_W-1:0] cycles(input int n);
    cycles = (n < 1) ? CNT_W'(1) : CNT_W'(n);
  endfunction : cycles

  assign pat_ok = (d_low_r[1] == PAT_D1_LOW) && (d_low_r[2] == PAT_D2_LOW)
               && (d_low_r[3] == PAT_D3_LOW) && (d_high_r[1] == PAT_D1_HIGH)
               && (d_high_r[2] == PAT_D2_HIGH) && (d_high_r[3] == PAT_D3_HIGH);

  always_comb begin
    addr_low_nxt  = addr_low_r;
    addr_high_nxt = addr_high_r;
    d_low_nxt     = d_low_r;
    d_high_nxt    = d_high_r;
    unlocked_nxt  = unlocked_r;
    sel_nxt       = sel_r;
    trig_nxt      = trig_r;
    prog_go_nxt   = prog_go_r;
    rd_allow_nxt  = rd_allow_r;
    rd_go_nxt     = rd_go_r;
    rst_pat_nxt   = rst_pat_r;
    clr_go_nxt    = clr_go_r;
    chip_rst_nxt  = 1'b0;
    st_nxt        = st_r;
    cnt_nxt       = cnt_r;
    buf_nxt       = buf_r;
    tag_nxt       = tag_r;
    // Register writes; accepted in every sequencer state, the CPU stall does not block them
    if (wr_go) begin
      unique case (1'b1)
        hit(i_wb_adr, OFS_ADDR_LOW):  addr_low_nxt = wbyte;
        hit(i_wb_adr, OFS_ADDR_HIGH): addr_high_nxt = wbyte[3:0] & ADDR_HIGH_MASK;
        hit(i_wb_adr, OFS_D0_LOW):    d_low_nxt[0] = wbyte;
        hit(i_wb_adr, OFS_D0_HIGH): begin
          d_high_nxt[0] = wbyte;
          if (unlocked_r) begin
            buf_nxt[addr_low_r[WORD_BITS-1:0]] = {wbyte, d_low_r[0]};
            tag_nxt[addr_low_r[WORD_BITS-1:0]] = 1'b1;
          end
          if (addr_low_r[WORD_BITS-1:0] != LAST_WORD) begin
            addr_low_nxt = addr_low_r + 8'h01;
          end
        end
        hit(i_wb_adr, OFS_D1_LOW):    d_low_nxt[1] = wbyte;
        hit(i_wb_adr, OFS_D1_HIGH):   d_high_nxt[1] = wbyte;
        hit(i_wb_adr, OFS_D2_LOW):    d_low_nxt[2] = wbyte;
        hit(i_wb_adr, OFS_D2_HIGH):   d_high_nxt[2] = wbyte;
        hit(i_wb_adr, OFS_D3_LOW):    d_low_nxt[3] = wbyte;
        hit(i_wb_adr, OFS_D3_HIGH):   d_high_nxt[3] = wbyte;
        hit(i_wb_adr, OFS_OP_CTRL): begin
          if (!wbyte[BIT_UNLOCKED]) begin
            unlocked_nxt = 1'b0;
          end
          sel_nxt      = wbyte[SEL_HI:SEL_LO];
          rd_allow_nxt = wbyte[BIT_READ_ALLOW];
        end
        hit(i_wb_adr, OFS_CHIP_RST): begin
          rst_pat_nxt  = wbyte;
          chip_rst_nxt = (wbyte == CHIP_RST_KEY);
        end
        default: ;
      endcase
    end
    // Sequencer
    unique case (st_r)
      ST_IDLE: begin
        if (trig_r && sel_r == SEL_UNLOCK) begin
          st_nxt  = ST_UNLOCK;
          cnt_nxt = cycles(UNLOCK_CYCLES);
        end else if (prog_go_r && unlocked_r && (sel_r == SEL_WRITE || sel_r == SEL_ERASE)) begin
          st_nxt  = ST_PROG;
          cnt_nxt = cycles(PROG_CYCLES);
        end else if (rd_go_r && rd_allow_r && sel_r == SEL_READ) begin
          st_nxt  = ST_READ;
          cnt_nxt = cycles(READ_CYCLES);
        end else if (clr_go_r) begin
          st_nxt  = ST_CLEAR;
          cnt_nxt = cycles(CLEAR_CYC);
        end else begin
          // Requests that cannot start are dropped so software sees them end
          trig_nxt    = 1'b0;
          prog_go_nxt = 1'b0;
          rd_go_nxt   = 1'b0;
        end
      end
      ST_UNLOCK: begin
        // Trigger window does not stall the CPU: software must write the pattern
        if (cnt_r == CNT_W'(1)) begin
          trig_nxt = 1'b0;
          if (pat_ok) begin
            unlocked_nxt = 1'b1;
          end
          st_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end
      end
      ST_PROG: begin
        if (cnt_r == CNT_W'(1)) begin
          prog_go_nxt = 1'b0;
          if (sel_r == SEL_WRITE) begin
            tag_nxt = '0;
            for (int i = 0; i < PAGE_WORDS; i++) begin
              buf_nxt[i] = 16'h0000;
            end
          end
          st_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end
      end
      ST_READ: begin
        if (cnt_r == CNT_W'(1)) begin
          rd_go_nxt     = 1'b0;
          d_low_nxt[0]  = i_fl_rdata[7:0];
          d_high_nxt[0] = i_fl_rdata[15:8];
          st_nxt        = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end
      end
      ST_CLEAR: begin
        if (cnt_r == CNT_W'(1)) begin
          clr_go_nxt = 1'b0;
          tag_nxt    = '0;
          for (int i = 0; i < PAGE_WORDS; i++) begin
            buf_nxt[i] = 16'h0000;
          end
          st_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    // Go bits set after the sequencer, so a software set beats a same-cycle hardware clear
    if (wr_go && hit(i_wb_adr, OFS_OP_CTRL)) begin
      if (wbyte[BIT_TRIGGER]) begin
        trig_nxt = 1'b1;
      end
      if (wbyte[BIT_PROG_GO]) begin
        prog_go_nxt = 1'b1;
      end
      if (wbyte[BIT_READ_GO]) begin
        rd_go_nxt = 1'b1;
      end
    end
    if (wr_go && hit(i_wb_adr, OFS_BUF_CLR) && wbyte[BIT_CLR_GO]) begin
      clr_go_nxt = 1'b1;
    end
  end

  // Read mux and ack; every offset answers, unmapped reads give zero
  always_comb begin
    ack_nxt  = i_wb_cyc && i_wb_stb && !ack_r;
    rdat_nxt = rdat_r;
    if (rd_go) begin
      rdat_nxt = 32'h0000_0000;
      unique case (1'b1)
        hit(i_wb_adr, OFS_ADDR_LOW):  rdat_nxt[7:0] = addr_low_r;
        hit(i_wb_adr, OFS_ADDR_HIGH): rdat_nxt[3:0] = addr_high_r;
        hit(i_wb_adr, OFS_D0_LOW):    rdat_nxt[7:0] = d_low_r[0];
        hit(i_wb_adr, OFS_D0_HIGH):   rdat_nxt[7:0] = d_high_r[0];
        hit(i_wb_adr, OFS_D1_LOW):    rdat_nxt[7:0] = d_low_r[1];
        hit(i_wb_adr, OFS_D1_HIGH):   rdat_nxt[7:0] = d_high_r[1];
        hit(i_wb_adr, OFS_D2_LOW):    rdat_nxt[7:0] = d_low_r[2];
        hit(i_wb_adr, OFS_D2_HIGH):   rdat_nxt[7:0] = d_high_r[2];
        hit(i_wb_adr, OFS_D3_LOW):    rdat_nxt[7:0] = d_low_r[3];
        hit(i_wb_adr, OFS_D3_HIGH):   rdat_nxt[7:0] = d_high_r[3];
        hit(i_wb_adr, OFS_OP_CTRL):   rdat_nxt[7:0] = {unlocked_r, sel_r, trig_r, prog_go_r, rd_allow_r, rd_go_r};
        hit(i_wb_adr, OFS_CHIP_RST):  rdat_nxt[7:0] = rst_pat_r;
        hit(i_wb_adr, OFS_BUF_CLR):   rdat_nxt[BIT_CLR_GO] = clr_go_r;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      addr_low_r  <= RST_BYTE;
      addr_high_r <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        d_low_r[i]  <= RST_BYTE;
        d_high_r[i] <= RST_BYTE;
      end
      unlocked_r  <= 1'b0;
      sel_r       <= SEL_WRITE;
      trig_r      <= 1'b0;
      prog_go_r   <= 1'b0;
      rd_allow_r  <= 1'b0;
      rd_go_r     <= 1'b0;
      rst_pat_r   <= RST_BYTE;
      clr_go_r    <= 1'b0;
      ack_r       <= 1'b0;
      rdat_r      <= 32'h0000_0000;
      chip_rst_r  <= 1'b0;
      st_r        <= ST_IDLE;
      cnt_r       <= '0;
      tag_r       <= '0;
      for (int i = 0; i < PAGE_WORDS; i++) begin
        buf_r[i] <= 16'h0000;
      end
    end else begin
      addr_low_r  <= addr_low_nxt;
      addr_high_r <= addr_high_nxt;
      d_low_r     <= d_low_nxt;
      d_high_r    <= d_high_nxt;
      unlocked_r  <= unlocked_nxt;
      sel_r       <= sel_nxt;
      trig_r      <= trig_nxt;
      prog_go_r   <= prog_go_nxt;
      rd_allow_r  <= rd_allow_nxt;
      rd_go_r     <= rd_go_nxt;
      rst_pat_r   <= rst_pat_nxt;
      clr_go_r    <= clr_go_nxt;
      ack_r       <= ack_nxt;
      rdat_r      <= rdat_nxt;
      chip_rst_r  <= chip_rst_nxt;
      st_r        <= st_nxt;
      cnt_r       <= cnt_nxt;
      tag_r       <= tag_nxt;
      buf_r       <= buf_nxt;
    end
  end

  assign o_wb_ack    = ack_r;
  assign o_wb_dat    = rdat_r;
  assign o_cpu_stall = (st_r == ST_PROG) || (st_r == ST_READ);
  assign o_chip_rst  = chip_rst_r;
  assign o_fl_wr     = (st_r == ST_PROG) && (cnt_r == CNT_W'(1)) && (sel_r == SEL_WRITE);
  assign o_fl_erase  = (st_r == ST_PROG) && (cnt_r == CNT_W'(1)) && (sel_r == SEL_ERASE);
  assign o_fl_rd     = (st_r == ST_READ) && (cnt_r == CNT_W'(1));
  assign o_fl_addr   = faddr;
  assign o_fl_wdata  = buf_r[addr_low_r[WORD_BITS-1:0]];
endmodule : fiap_ctrl

// ---- testbench/fiap_ctrl_assertions.sv ----
// Port-level checker for the flash IN_APP_PROGRAMMING control block
`timescale 1ns/1ps
module fiap_ctrl_assertions
  import fiap_pkg::*;
#(
  parameter int UNLOCK_CYCLES = 200,
  parameter int PROG_CYCLES   = 2000,
  parameter int READ_CYCLES   = 10
) (
  input wire logic                i_core_clk,   // Clock
  input wire logic                i_arst_n,     // Reset
  input wire logic                i_wb_cyc,     // Cycle
  input wire logic                i_wb_stb,     // Strobe
  input wire logic                i_wb_we,      // Write
  input wire logic [ADDR_W-1:0]   i_wb_adr,     // Address
  input wire logic [DATA_W-1:0]   i_wb_dat,     // Write data
  input wire logic [3:0]          i_wb_sel,     // Selects
  input wire logic [DATA_W-1:0]   o_wb_dat,     // Read data
  input wire logic                o_wb_ack,     // Ack
  input wire logic                o_cpu_stall,  // Stall
  input wire logic                o_chip_rst,   // Chip reset
  input wire logic                o_fl_wr,      // Program strobe
  input wire logic                o_fl_erase,   // Erase strobe
  input wire logic                o_fl_rd,      // Read strobe
  input wire logic [FLASH_AW-1:0] o_fl_addr,    // Flash address
  input wire logic [15:0]         o_fl_wdata,   // Buffer word
  input wire logic [15:0]         i_fl_rdata    // Flash word
);
  logic        take;
  logic        wtake;
  logic [15:0] stall_cnt_r;
  logic [15:0] stall_cnt_nxt;
  assign take  = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wtake = take && i_wb_we && i_wb_sel[0];
  // Length of the current stall run, compared when it ends
  always_comb stall_cnt_nxt = o_cpu_stall ? stall_cnt_r + 16'h1 : 16'h0;
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) stall_cnt_r <= 16'h0;
    else stall_cnt_r <= stall_cnt_nxt;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  a_ack_one_shot: assert property (take |=> o_wb_ack ##1 !o_wb_ack) else $error("ack not a single pulse");
  a_high_addr_zero: assert property (
    o_wb_ack && !$past(i_wb_we) && $past(i_wb_adr) == OFS_ADDR_HIGH |-> o_wb_dat[7:4] == 4'h0)
    else $error("upper address bits not zero");
  a_clear_upper_zero: assert property (
    o_wb_ack && !$past(i_wb_we) && $past(i_wb_adr) == OFS_BUF_CLR |-> o_wb_dat[7:1] == 7'h0)
    else $error("buffer clear upper bits not zero");
  a_low_no_load: assert property (wtake && i_wb_adr == OFS_D0_LOW |=> $stable(o_fl_addr))
    else $error("low data write moved address");
  a_load_increments: assert property (wtake && i_wb_adr == OFS_D0_HIGH |=>
    o_fl_addr == ($past(o_fl_addr[4:0]) == LAST_WORD ? $past(o_fl_addr) : $past(o_fl_addr) + 12'h1))
    else $error("address step after load wrong");
  a_chip_rst_key: assert property (
    wtake && i_wb_adr == OFS_CHIP_RST && i_wb_dat[7:0] == CHIP_RST_KEY |-> ##[1:2] o_chip_rst)
    else $error("chip reset not raised");
  a_chip_rst_pulse: assert property (o_chip_rst |=> !o_chip_rst) else $error("chip reset too long");
  a_stall_length: assert property (
    $fell(o_cpu_stall) |-> stall_cnt_r == 16'(PROG_CYCLES) || stall_cnt_r == 16'(READ_CYCLES))
    else $error("stall length wrong");
  a_strobe_onehot: assert property ($onehot0({o_fl_wr, o_fl_erase, o_fl_rd}))
    else $error("several flash strobes");
  a_strobe_in_stall: assert property ((o_fl_wr || o_fl_erase || o_fl_rd) |-> o_cpu_stall)
    else $error("strobe outside stall");
  a_reset_quiet: assert property (!$past(i_arst_n) |-> !o_cpu_stall && !o_wb_ack && o_fl_addr == 12'h0)
    else $error("outputs not clear after reset");
  c_load: cover property (wtake && i_wb_adr == OFS_D0_HIGH);
  c_stall_end: cover property ($fell(o_cpu_stall));
  c_chip_rst: cover property (o_chip_rst);
  c_read: cover property (o_fl_rd);
endmodule : fiap_ctrl_assertions

bind fiap_ctrl fiap_ctrl_assertions #(.UNLOCK_CYCLES(UNLOCK_CYCLES), .PROG_CYCLES(PROG_CYCLES),
  .READ_CYCLES(READ_CYCLES)) u_fiap_ctrl_assertions (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat),
  .i_wb_sel(i_wb_sel), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_cpu_stall(o_cpu_stall),
  .o_chip_rst(o_chip_rst), .o_fl_wr(o_fl_wr), .o_fl_erase(o_fl_erase), .o_fl_rd(o_fl_rd),
  .o_fl_addr(o_fl_addr), .o_fl_wdata(o_fl_wdata), .i_fl_rdata(i_fl_rdata));

// ---- testbench/tb_fiap_ctrl.sv ----
// Self-checking testbench for the flash IN_APP_PROGRAMMING control block
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_fiap_ctrl;
  import fiap_pkg::*;
  localparam int UNL = 40;  // Long enough for six pattern writes
  logic i_core_clk = 0, i_arst_n = 0, i_wb_cyc = 0, i_wb_stb = 0, i_wb_we = 0;
  logic [5:0] i_wb_adr = 6'h0;
  logic [31:0] i_wb_dat = 32'h0, o_wb_dat;
  logic [3:0] i_wb_sel = 4'h0;
  logic [15:0] i_fl_rdata = 16'hbeef, o_fl_wdata;
  logic [11:0] o_fl_addr;
  logic o_wb_ack, o_cpu_stall, o_chip_rst, o_fl_wr, o_fl_erase, o_fl_rd;
  logic [7:0] q;
  int fail_count = 0, n_compared = 0, n_wr = 0, n_er = 0, n_rd = 0, n_rst = 0, c;
  fiap_ctrl #(.UNLOCK_CYCLES(UNL), .PROG_CYCLES(4), .READ_CYCLES(4)) u_fiap_ctrl (.i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
    .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .o_cpu_stall(o_cpu_stall), .o_chip_rst(o_chip_rst), .o_fl_wr(o_fl_wr), .o_fl_erase(o_fl_erase),
    .o_fl_rd(o_fl_rd), .o_fl_addr(o_fl_addr), .o_fl_wdata(o_fl_wdata), .i_fl_rdata(i_fl_rdata));
  initial forever #5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    n_wr  += int'(o_fl_wr === 1'b1);
    n_er  += int'(o_fl_erase === 1'b1);
    n_rd  += int'(o_fl_rd === 1'b1);
    n_rst += int'(o_chip_rst === 1'b1);
  end
  task automatic close_out;
    $display("compared %0d, failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  // Classic single cycle; held until ack is sampled
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat, i_wb_sel} <= {2'b11, w, a, 24'h0, d, 4'hf};
    for (int n = 0; n < 20; n++) begin
      @(posedge i_core_clk);
      if (o_wb_ack === 1'b1) begin
        q = o_wb_dat[7:0];
        {i_wb_cyc, i_wb_stb, i_wb_we} <= 3'b000;
        return;
      end
    end
    fail_count++;
    close_out();
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [7:0] d); bus(1'b1, a, d); endtask : wr
  task automatic rchk(input logic [5:0] a, input logic [7:0] e); bus(1'b0, a, 8'h0); `CHK(q, e) endtask : rchk
  task automatic wait_done;
    repeat (2) @(posedge i_core_clk);
    for (int n = 0; n < 100; n++) begin
      @(posedge i_core_clk);
      if (o_cpu_stall === 1'b0) return;
    end
    fail_count++;
    close_out();
  endtask : wait_done
  task automatic t_regs;
    logic [5:0] ofs [13] = '{OFS_ADDR_LOW, OFS_ADDR_HIGH, OFS_D0_LOW, OFS_D0_HIGH, OFS_D1_LOW, OFS_D1_HIGH,
      OFS_D2_LOW, OFS_D2_HIGH, OFS_D3_LOW, OFS_D3_HIGH, OFS_OP_CTRL, OFS_CHIP_RST, OFS_BUF_CLR};
    foreach (ofs[i]) rchk(ofs[i], 8'h00);
    rchk(6'h34, 8'h00);
    wr(OFS_ADDR_HIGH, 8'hff);
    rchk(OFS_ADDR_HIGH, 8'h0f);
    for (int i = 0; i < 6; i++) wr(6'(OFS_D1_LOW + 4 * i), 8'(8'ha0 + i));
    for (int i = 0; i < 6; i++) rchk(6'(OFS_D1_LOW + 4 * i), 8'(8'ha0 + i));
    wr(OFS_OP_CTRL, 8'h80);
    rchk(OFS_OP_CTRL, 8'h00);
    wr(OFS_BUF_CLR, 8'hff);
    rchk(OFS_BUF_CLR, 8'h01);
    repeat (CLEAR_CYC + 2) @(posedge i_core_clk);
    rchk(OFS_BUF_CLR, 8'h00);
    c = n_rst;
    wr(OFS_CHIP_RST, 8'h54);
    wr(OFS_CHIP_RST, CHIP_RST_KEY);
    @(posedge i_core_clk);
    `CHK(n_rst, c + 1)
    $display("registers test done");
  endtask : t_regs
  task automatic t_unlock;
    logic [7:0] pat [6] = '{PAT_D1_LOW, PAT_D1_HIGH, PAT_D2_LOW, PAT_D2_HIGH, PAT_D3_LOW, PAT_D3_HIGH};
    wr(OFS_OP_CTRL, 8'h68);
    rchk(OFS_OP_CTRL, 8'h68);
    repeat (UNL + 4) @(posedge i_core_clk);
    rchk(OFS_OP_CTRL, 8'h60);
    wr(OFS_OP_CTRL, 8'h68);
    for (int i = 0; i < 6; i++) wr(6'(OFS_D1_LOW + 4 * i), pat[i]);
    repeat (UNL) @(posedge i_core_clk);
    rchk(OFS_OP_CTRL, 8'he0);
    $display("unlock test done");
  endtask : t_unlock
  task automatic t_program;
    logic [2:0] rsv [4] = '{3'h2, 3'h4, 3'h5, 3'h7};
    wr(OFS_ADDR_HIGH, 8'h03);
    wr(OFS_ADDR_LOW, 8'h1e);
    wr(OFS_D0_LOW, 8'h34);
    `CHK(o_fl_addr, 12'h31e)
    wr(OFS_D0_HIGH, 8'h12);
    `CHK(o_fl_addr, 12'h31f)
    wr(OFS_D0_LOW, 8'h78);
    wr(OFS_D0_HIGH, 8'h56);
    `CHK(o_fl_addr, 12'h31f)
    `CHK(o_fl_wdata, 16'h5678)
    wr(OFS_ADDR_LOW, 8'h1e);
    `CHK(o_fl_wdata, 16'h1234)
    wr(OFS_BUF_CLR, 8'h01);
    repeat (CLEAR_CYC + 2) @(posedge i_core_clk);
    `CHK(o_fl_wdata, 16'h0000)
    c = n_wr;
    wr(OFS_OP_CTRL, 8'h84);
    wait_done();
    `CHK(n_wr, c + 1)
    rchk(OFS_OP_CTRL, 8'h80);
    c = n_er;
    wr(OFS_OP_CTRL, 8'h94);
    wait_done();
    `CHK(n_er, c + 1)
    foreach (rsv[i]) begin
      wr(OFS_OP_CTRL, {1'b1, rsv[i], 4'h4});
      repeat (3) @(posedge i_core_clk);
      rchk(OFS_OP_CTRL, {1'b1, rsv[i], 4'h0});
    end
    `CHK(n_wr + n_er, c + 2)
    wr(OFS_OP_CTRL, 8'h10);
    rchk(OFS_OP_CTRL, 8'h10);
    wr(OFS_OP_CTRL, 8'h14);
    repeat (8) @(posedge i_core_clk);
    `CHK(n_er, c + 1)
    $display("program test done");
  endtask : t_program
  task automatic t_read;
    wr(OFS_ADDR_LOW, 8'h05);
    c = n_rd;
    wr(OFS_OP_CTRL, 8'h31);
    repeat (8) @(posedge i_core_clk);
    `CHK(n_rd, c)
    wr(OFS_OP_CTRL, 8'h32);
    wr(OFS_OP_CTRL, 8'h33);
    wait_done();
    `CHK(n_rd, c + 1)
    rchk(OFS_OP_CTRL, 8'h32);
    rchk(OFS_D0_LOW, 8'hef);
    rchk(OFS_D0_HIGH, 8'hbe);
    $display("read test done");
  endtask : t_read
  initial begin
    repeat (5) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    t_regs();
    t_unlock();
    t_program();
    t_read();
    close_out();
  end
endmodule : tb_fiap_ctrl
